// ### logic/foc_estimator_status_regs.sv
// Purpose: Read-only status bank showing sensorless estimator observations.
// Assumes: Estimator strobes are on the register clock; reads are one-cycle strobes.
// Notes:   Read data stand in the cycle after the read strobe and only there.
//
// Function
// - Hold absolute startup rotation rate, 32 bits.
// - Show standstill sensing step as code 0..A.
// - Position code reads B done, C fault.
// - Hold signed standstill rotor angle, 32 bits.
// - Hold signed direct-axis back-EMF estimate.
// - Hold signed quadrature-axis back-EMF estimate.
// - Hold signed rotor rotation rate estimate.
// - Hold signed rotor angle estimate.
// - Show startup sensing step, 5 done, 6 fault.
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module foc_estimator_status_regs
    import foc_status_pkg::*;
(
    input  wire logic                  clock,                // 200 MHz system clock
    input  wire logic                  rst_n,                // Asynchronous reset, active low
    // Software register port
    input  wire logic [ADDR_WIDTH-1:0] addr,                 // Register offset
    input  wire logic [DATA_WIDTH-1:0] wr_data,              // Write data, ignored
    input  wire logic                  wr_en,                // Write strobe, ignored
    input  wire logic                  rd_en,                // Read strobe
    output logic      [DATA_WIDTH-1:0] rd_data,              // Read data, one cycle later
    output logic                       rd_valid,             // Marks the read data cycle
    // Startup rotation sensing side
    input  wire logic                  startup_step_valid,   // New startup step code
    input  wire logic [CODE_WIDTH-1:0] startup_step_code,    // Step code 0..4
    input  wire logic                  startup_sense_done,   // Startup sensing finished
    input  wire logic                  startup_sense_fault,  // Startup sensing failed
    input  wire logic                  startup_rate_valid,   // New startup rate sample
    input  wire logic [DATA_WIDTH-1:0] startup_rate_signed,  // Signed startup rate
    // Standstill position sensing side
    input  wire logic                  position_step_valid,  // New position step code
    input  wire logic [CODE_WIDTH-1:0] position_step_code,   // Step code 0..A
    input  wire logic                  position_sense_done,  // Position sensing finished
    input  wire logic                  position_sense_fault, // Position sensing failed
    input  wire logic                  angle_result_valid,   // New standstill angle
    input  wire logic [DATA_WIDTH-1:0] angle_result,         // Signed standstill angle
    // Running estimator side
    input  wire logic                  estimate_valid,       // New estimator sample set
    input  wire logic [DATA_WIDTH-1:0] back_emf_direct,      // Signed d-axis back-EMF
    input  wire logic [DATA_WIDTH-1:0] back_emf_quadrature,  // Signed q-axis back-EMF
    input  wire logic [DATA_WIDTH-1:0] rotor_velocity,       // Signed rotation rate
    input  wire logic [DATA_WIDTH-1:0] rotor_angle           // Signed angle, may exceed a turn
);

    // Number of plain 32-bit value registers
    localparam int unsigned NUM_WORDS = 6;

    // Index of each value register in the capture array
    localparam int unsigned IDX_RATE    = 0;
    localparam int unsigned IDX_ANGLE   = 1;
    localparam int unsigned IDX_EMF_D   = 2;
    localparam int unsigned IDX_EMF_Q   = 3;
    localparam int unsigned IDX_VEL     = 4;
    localparam int unsigned IDX_THETA   = 5;

    // Progress code state
    startup_progress_t  startup_progress;                   // Startup sensing code
    startup_progress_t  next_startup_progress;              // Its next value
    position_progress_t position_progress;                  // Position sensing code
    position_progress_t next_position_progress;             // Its next value

    // Value capture wiring
    logic [DATA_WIDTH-1:0] word_in   [NUM_WORDS];           // Value offered to each word
    logic                  word_load [NUM_WORDS];           // Load strobe of each word
    logic [DATA_WIDTH-1:0] word_q    [NUM_WORDS];           // Stored words

    // Read path state
    logic [DATA_WIDTH-1:0] next_rd_data;                    // Word selected this cycle
    logic                  next_rd_valid;                   // Read strobe seen this cycle
    logic [DATA_WIDTH-1:0] rate_magnitude;                  // Absolute startup rate

    // Absolute value of the startup rate; the most negative input saturates,
    // since its true magnitude does not fit in a signed 32-bit word
    always_comb begin
        if (startup_rate_signed[DATA_WIDTH-1]) begin
            if (startup_rate_signed == ~MAX_MAGNITUDE) begin
                rate_magnitude = MAX_MAGNITUDE;
            end else begin
                rate_magnitude = (~startup_rate_signed) + 32'h0000_0001;
            end
        end else begin
            rate_magnitude = startup_rate_signed;
        end
    end

    // Route each source to its capture word; signed values other than the startup rate pass untouched
    always_comb begin
        word_in[IDX_RATE]    = rate_magnitude;
        word_load[IDX_RATE]  = startup_rate_valid;
        word_in[IDX_ANGLE]   = angle_result;
        word_load[IDX_ANGLE] = angle_result_valid;
        word_in[IDX_EMF_D]   = back_emf_direct;
        word_load[IDX_EMF_D] = estimate_valid;
        word_in[IDX_EMF_Q]   = back_emf_quadrature;
        word_load[IDX_EMF_Q] = estimate_valid;
        word_in[IDX_VEL]     = rotor_velocity;
        word_load[IDX_VEL]   = estimate_valid;
        // Stored without wrapping; reduction to one turn is left to software
        word_in[IDX_THETA]   = rotor_angle;
        word_load[IDX_THETA] = estimate_valid;
    end

    // One capture word per value register
    genvar gi;
    generate
        for (gi = 0; gi < NUM_WORDS; gi++) begin : g_word
            status_capture #(
                .WIDTH (DATA_WIDTH)
            ) u_word (
                .clock (clock),
                .rst_n (rst_n),
                .load  (word_load[gi]),
                .value (word_in[gi]),
                .held  (word_q[gi])
            );
        end
    endgenerate

    // Startup progress: fault outranks done, done outranks a step;
    // a step code above the direction check is not a step and is dropped
    always_comb begin
        next_startup_progress = startup_progress;
        if (startup_sense_fault) begin
            next_startup_progress = STARTUP_FAULT;
        end else if (startup_sense_done) begin
            next_startup_progress = STARTUP_COMPLETE;
        end else if (startup_step_valid &&
                     startup_step_code <= CODE_WIDTH'(STARTUP_DIRECTION_CHECK)) begin
            next_startup_progress = startup_progress_t'(startup_step_code);
        end
    end

    // Position progress: same priority; steps above the angle calculation
    // are dropped so the end codes can only come from the two flags
    always_comb begin
        next_position_progress = position_progress;
        if (position_sense_fault) begin
            next_position_progress = POSITION_FAULT;
        end else if (position_sense_done) begin
            next_position_progress = POSITION_DONE;
        end else if (position_step_valid &&
                     position_step_code <= CODE_WIDTH'(POSITION_CALC_ANGLE)) begin
            next_position_progress = position_progress_t'(position_step_code);
        end
    end

    // Progress registers; zero after reset
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            startup_progress  <= STARTUP_INIT;
            position_progress <= POSITION_INIT;
        end else begin
            startup_progress  <= next_startup_progress;
            position_progress <= next_position_progress;
        end
    end

    // Read decode; writes have no path into any register, and a read
    // changes nothing but the read data, so polling is always safe
    always_comb begin
        next_rd_valid = rd_en;
        next_rd_data  = UNMAPPED_WORD;
        if (rd_en) begin
            unique case (addr)
                OFS_STARTUP_PROGRESS: begin
                    next_rd_data = {16'h0000, startup_progress};
                end
                OFS_STARTUP_RATE: begin
                    next_rd_data = word_q[IDX_RATE];
                end
                OFS_POSITION_PROGRESS: begin
                    next_rd_data = {16'h0000, position_progress};
                end
                OFS_STANDSTILL_ANGLE: begin
                    next_rd_data = word_q[IDX_ANGLE];
                end
                OFS_BACK_EMF_DIRECT: begin
                    next_rd_data = word_q[IDX_EMF_D];
                end
                OFS_BACK_EMF_QUADRATURE: begin
                    next_rd_data = word_q[IDX_EMF_Q];
                end
                OFS_ROTOR_VELOCITY: begin
                    next_rd_data = word_q[IDX_VEL];
                end
                OFS_ROTOR_ANGLE: begin
                    next_rd_data = word_q[IDX_THETA];
                end
                default: begin
                    next_rd_data = UNMAPPED_WORD;                 // Unknown offset reads zero
                end
            endcase
        end
    end

    // Read data stand for exactly the cycle after the strobe, zero otherwise
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rd_data  <= RESET_WORD;
            rd_valid <= 1'b0;
        end else begin
            rd_data  <= next_rd_data;
            rd_valid <= next_rd_valid;
        end
    end

    // Write port is accepted and discarded
    logic unused_write;                                     // Sink for ignored inputs
    assign unused_write = wr_en ^ (^wr_data);

endmodule : foc_estimator_status_regs

`default_nettype wire

// ### logic/status_capture.sv
// Purpose: One read-only status word, loaded by the estimator side.
// Assumes: Load strobe and value come from logic on the same clock.
// Notes:   Resets to zero; software has no path to write it.
`timescale 1ns/1ps
`default_nettype none

module status_capture
    import foc_status_pkg::*;
#(
    parameter int unsigned WIDTH = 32               // Width of the held value
) (
    input  wire logic             clock,            // System clock
    input  wire logic             rst_n,            // Asynchronous reset, active low
    input  wire logic             load,             // Take value this cycle
    input  wire logic [WIDTH-1:0] value,            // New value from the estimator
    output logic      [WIDTH-1:0] held              // Stored value
);

    logic [WIDTH-1:0] next_held;                    // Value for the next edge

    // Keep the old word unless a load arrives
    always_comb begin
        next_held = held;
        if (load) begin
            next_held = value;
        end
    end

    // Register only; reset to zero
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            held <= '0;
        end else begin
            held <= next_held;
        end
    end

endmodule : status_capture

`default_nettype wire

// ### shared/foc_status_pkg.sv
// Purpose: Shared constants and codes for the estimator status register bank.
// Assumes: Registers sit at fixed offsets on a plain 12-bit address port.
// Notes:   All values are fixed point with 27 fraction bits; reset value is zero.
package foc_status_pkg;

    // Register port geometry
    localparam int unsigned ADDR_WIDTH = 12;           // Wide enough for the top offset
    localparam int unsigned DATA_WIDTH = 32;           // Word width of every register
    localparam int unsigned CODE_WIDTH = 16;           // Width of the progress codes

    // Register offsets on the software port
    localparam logic [11:0] OFS_STARTUP_PROGRESS    = 12'h6F0;
    localparam logic [11:0] OFS_STARTUP_RATE        = 12'h6FA;
    localparam logic [11:0] OFS_POSITION_PROGRESS   = 12'h724;
    localparam logic [11:0] OFS_STANDSTILL_ANGLE    = 12'h746;
    localparam logic [11:0] OFS_BACK_EMF_DIRECT     = 12'h772;
    localparam logic [11:0] OFS_BACK_EMF_QUADRATURE = 12'h774;
    localparam logic [11:0] OFS_ROTOR_VELOCITY      = 12'h784;
    localparam logic [11:0] OFS_ROTOR_ANGLE         = 12'h788;

    // Reset values
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;   // Every value register
    localparam logic [15:0] RESET_CODE = 16'h0000;        // Every progress register
    localparam logic [31:0] UNMAPPED_WORD = 32'h0000_0000; // Answer to an unknown offset

    // Saturated magnitude for the most negative startup rate
    localparam logic [31:0] MAX_MAGNITUDE = 32'h7FFF_FFFF;

    // Startup rotation sensing progress codes
    typedef enum logic [15:0] {
        STARTUP_INIT            = 16'h0000,
        STARTUP_STOP_CHECK      = 16'h0001,
        STARTUP_ESTIMATOR_INIT  = 16'h0002,
        STARTUP_RUNNING_CHECK   = 16'h0003,
        STARTUP_DIRECTION_CHECK = 16'h0004,
        STARTUP_COMPLETE        = 16'h0005,
        STARTUP_FAULT           = 16'h0006
    } startup_progress_t;

    // Standstill position sensing progress codes
    typedef enum logic [15:0] {
        POSITION_INIT          = 16'h0000,
        POSITION_VECTOR_CONFIG = 16'h0001,
        POSITION_RUN           = 16'h0002,
        POSITION_SLOW_RISE     = 16'h0003,
        POSITION_SLOW_FALL     = 16'h0004,
        POSITION_DECAY_WAIT    = 16'h0005,
        POSITION_TIME_CAPTURE  = 16'h0006,
        POSITION_NEXT_VECTOR   = 16'h0007,
        POSITION_CALC_SECTOR   = 16'h0008,
        POSITION_CALC_ROTOR    = 16'h0009,
        POSITION_CALC_ANGLE    = 16'h000A,
        POSITION_DONE          = 16'h000B,
        POSITION_FAULT         = 16'h000C
    } position_progress_t;

endpackage : foc_status_pkg

// ### verification/foc_status_regs_asserts.sv
// Purpose: Concurrent checks on the estimator status register bank.
// Assumes: Sees only top-level ports; one clock domain.
// Notes:   A load is judged through a read strobe one cycle after it.
`timescale 1ns/1ps
`default_nettype none

module status_regs_checker
    import foc_status_pkg::*;
(
    input wire logic                  clock,                // System clock
    input wire logic                  rst_n,                // Reset, active low
    input wire logic [ADDR_WIDTH-1:0] addr,                 // Register offset
    input wire logic                  rd_en,                // Read strobe
    input wire logic [DATA_WIDTH-1:0] rd_data,              // Read word
    input wire logic                  rd_valid,             // Read data cycle
    input wire logic                  startup_rate_valid,   // Rate load
    input wire logic [DATA_WIDTH-1:0] startup_rate_signed,  // Signed rate
    input wire logic                  startup_sense_fault,  // Startup failed
    input wire logic                  position_sense_done,  // Position done
    input wire logic                  position_sense_fault, // Position failed
    input wire logic                  angle_result_valid,   // Angle load
    input wire logic [DATA_WIDTH-1:0] angle_result,         // Standstill angle
    input wire logic                  estimate_valid,       // Estimate load
    input wire logic [DATA_WIDTH-1:0] back_emf_direct,      // D-axis value
    input wire logic [DATA_WIDTH-1:0] back_emf_quadrature,  // Q-axis value
    input wire logic [DATA_WIDTH-1:0] rotor_velocity,       // Rotation rate
    input wire logic [DATA_WIDTH-1:0] rotor_angle           // Rotor angle
);
    // Single domain, so clock and reset are given once
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    // A read strobe aimed at one offset
    sequence rd_at(logic [11:0] a);
        rd_en && addr == a;
    endsequence

    // Load, read next cycle, then the loaded word; reset mid-way cancels it
    property loaded_read(logic v, logic [11:0] a, logic [31:0] x);
        v ##1 rd_at(a) |=> rd_data == $past(x, 2);
    endproperty

    rd_answer_a: assert property (rd_en |=> rd_valid)
        else $error("read strobe without valid");
    rd_idle_a: assert property (!rd_en |=> !rd_valid && rd_data == '0)
        else $error("read data outside read cycle");
    rate_abs_a: assert property (loaded_read(startup_rate_valid && !startup_rate_signed[31], OFS_STARTUP_RATE, startup_rate_signed))
        else $error("startup rate word wrong");
    still_angle_a: assert property (loaded_read(angle_result_valid, OFS_STANDSTILL_ANGLE, angle_result))
        else $error("standstill angle wrong");
    emf_direct_a: assert property (loaded_read(estimate_valid, OFS_BACK_EMF_DIRECT, back_emf_direct))
        else $error("direct back emf wrong");
    emf_quad_a: assert property (loaded_read(estimate_valid, OFS_BACK_EMF_QUADRATURE, back_emf_quadrature))
        else $error("quadrature back emf wrong");
    velocity_read_a: assert property (loaded_read(estimate_valid, OFS_ROTOR_VELOCITY, rotor_velocity))
        else $error("rotor velocity wrong");
    rotor_angle_a: assert property (loaded_read(estimate_valid, OFS_ROTOR_ANGLE, rotor_angle))
        else $error("rotor angle wrong");
    pos_done_a: assert property (position_sense_done && !position_sense_fault ##1 rd_at(OFS_POSITION_PROGRESS) |=> rd_data == 32'h0000_000B)
        else $error("position done code wrong");
    pos_fault_a: assert property (position_sense_fault ##1 rd_at(OFS_POSITION_PROGRESS) |=> rd_data == 32'h0000_000C)
        else $error("position fault code wrong");
    start_fault_a: assert property (startup_sense_fault ##1 rd_at(OFS_STARTUP_PROGRESS) |=> rd_data == 32'h0000_0006)
        else $error("startup fault code wrong");
endmodule : status_regs_checker

bind foc_estimator_status_regs status_regs_checker chk_u (.*);

`default_nettype wire

// ### verification/tb_top.sv
// Purpose: Self-checking bench for the estimator status register bank.
// Assumes: Every task but chk is entered in the time step of a rising edge; chk runs at falling edges.
// Notes:   Each load is read back in the very next cycle.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import foc_status_pkg::*;
    logic                  clock = 1'b0;   // 200 MHz clock
    logic                  rst_n = 1'b0;   // Reset, active low
    logic [ADDR_WIDTH-1:0] addr = '0;      // Register offset
    logic [DATA_WIDTH-1:0] wr_data = '0, rd_data;
    logic                  wr_en = 0, rd_en = 0, rd_valid;
    logic                  startup_step_valid = 0, startup_sense_done = 0;
    logic                  startup_sense_fault = 0, startup_rate_valid = 0;
    logic                  position_step_valid = 0, position_sense_done = 0;
    logic                  position_sense_fault = 0, angle_result_valid = 0;
    logic                  estimate_valid = 0;
    logic [CODE_WIDTH-1:0] startup_step_code = '0, position_step_code = '0;
    logic [DATA_WIDTH-1:0] startup_rate_signed = '0, angle_result = '0;
    logic [DATA_WIDTH-1:0] back_emf_direct = '0, back_emf_quadrature = '0;
    logic [DATA_WIDTH-1:0] rotor_velocity = '0, rotor_angle = '0;
    int                    n_mismatch = 0, total_checks = 0, cycles = 0;
    // Every mapped offset, for sweeps
    logic [11:0] ofs [8] = '{OFS_STARTUP_PROGRESS, OFS_STARTUP_RATE, OFS_POSITION_PROGRESS,
        OFS_STANDSTILL_ANGLE, OFS_BACK_EMF_DIRECT, OFS_BACK_EMF_QUADRATURE,
        OFS_ROTOR_VELOCITY, OFS_ROTOR_ANGLE};

    foc_estimator_status_regs dut_u (.*);

    // Clock toggles each half period
    always #2.5 clock = ~clock;

    // Hang guard; the whole run needs well under a thousand cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            wrap_up();
        end
    end

    // Compare and count; unknowns never match
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One-cycle read; data judged mid-cycle, then judged gone one cycle later;
    // returns on a rising edge so the next task drives right after it
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        rd_en <= 1'b1;
        addr  <= a;
        @(posedge clock);
        rd_en <= 1'b0;
        @(negedge clock);
        chk({31'h0, rd_valid}, 32'h1);
        chk(rd_data, e);
        @(negedge clock);
        chk({31'h0, rd_valid}, 32'h0);
        chk(rd_data, 32'h0);
        @(posedge clock);
    endtask : rd

    // Pulse strobe group k (step, done, fault) on one side, then read it
    task automatic prog(input bit st, input logic [2:0] k, input logic [15:0] c,
                        input logic [31:0] e);
        if (st) {startup_sense_fault, startup_sense_done, startup_step_valid} <= k;
        else {position_sense_fault, position_sense_done, position_step_valid} <= k;
        startup_step_code  <= c;
        position_step_code <= c;
        @(posedge clock);
        {startup_sense_fault, startup_sense_done, startup_step_valid} <= 3'b000;
        {position_sense_fault, position_sense_done, position_step_valid} <= 3'b000;
        rd(st ? OFS_STARTUP_PROGRESS : OFS_POSITION_PROGRESS, e);
    endtask : prog

    // Zero after reset, writes change nothing, unmapped reads zero
    task automatic t_quiet;
        foreach (ofs[i]) begin
            wr_en <= 1'b1;
            addr <= ofs[i];
            wr_data <= 32'hFFFF_FFFF;
            @(posedge clock);
            wr_en <= 1'b0;
            rd(ofs[i], 32'h0);
        end
        rd(12'h700, 32'h0);
        $display("test quiet done");
    endtask : t_quiet

    // Signed values held as is; angle beyond one turn stays unwrapped
    task automatic t_values;
        logic [31:0] v [5] = '{32'hC000_0000, 32'hF000_0001, 32'h0800_0000,
                               32'hFC00_0000, 32'h0871_C71C};
        foreach (v[i]) begin
            estimate_valid <= 1'b1;
            angle_result_valid <= 1'b1;
            angle_result <= v[0];
            back_emf_direct <= v[1];
            back_emf_quadrature <= v[2];
            rotor_velocity <= v[3];
            rotor_angle <= v[4];
            @(posedge clock);
            {estimate_valid, angle_result_valid} <= 2'b00;
            rd(ofs[i + 3], v[i]);
        end
        $display("test values done");
    endtask : t_values

    // Startup rate is a magnitude; most negative saturates
    task automatic t_rate;
        logic [31:0] s [3] = '{32'hFFFF_FFFE, 32'h8000_0000, 32'h0123_4567};
        logic [31:0] e [3] = '{32'h0000_0002, MAX_MAGNITUDE, 32'h0123_4567};
        foreach (s[i]) begin
            startup_rate_valid <= 1'b1;
            startup_rate_signed <= s[i];
            @(posedge clock);
            startup_rate_valid <= 1'b0;
            rd(OFS_STARTUP_RATE, e[i]);
        end
        $display("test rate done");
    endtask : t_rate

    // Every step code, out-of-range drop, end codes and fault priority
    task automatic t_progress;
        for (int c = 0; c <= 10; c++) prog(0, 3'b001, c[15:0], c);
        prog(0, 3'b001, 16'h000D, 32'hA);
        prog(0, 3'b010, 16'h0, 32'hB);
        prog(0, 3'b100, 16'h0, 32'hC);
        prog(0, 3'b111, 16'h0, 32'hC);
        for (int c = 0; c <= 4; c++) prog(1, 3'b001, c[15:0], c);
        prog(1, 3'b001, 16'h0007, 32'h4);
        prog(1, 3'b010, 16'h0, 32'h5);
        prog(1, 3'b100, 16'h0, 32'h6);
        $display("test progress done");
    endtask : t_progress

    // Mid-run reset clears every register, progress codes included
    task automatic t_reset;
        rst_n <= 1'b0;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        foreach (ofs[i]) rd(ofs[i], 32'h0);
        $display("test reset done");
    endtask : t_reset

    // Verdict in one place
    task automatic wrap_up;
        $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : wrap_up

    // Main sequence, with a second reset after loads
    initial begin
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        t_quiet();
        t_values();
        t_rate();
        t_progress();
        t_reset();
        wrap_up();
    end
endmodule : tb_top

`default_nettype wire
